// ### rtl/fp_coprocessor_transfer_access.v
// Register-pair transfers and system-register access of the floating-point coprocessor.
`timescale 1ns/100ps
`default_nettype none
`include "fp_xfer_regs.vh"
module fp_coprocessor_transfer_access #(
  // The identity value is arbitrary.
  parameter [31:0] SYSTEM_ID = 32'h00C0FFEE
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Issued instruction
  input wire issueValid,
  input wire conditionPassed,
  input wire [2:0] issueOp,
  input wire [4:0] doubleReg,
  input wire [3:0] singleIndexHigh,
  input wire singleIndexLowBit,
  input wire [3:0] sysregSelect,
  input wire [31:0] issueWord,
  input wire privilegedMode,
  // Core register values
  input wire [31:0] coreRegFirstIn,
  input wire [31:0] coreRegSecondIn,
  // Core register results
  output reg coreWriteValid,
  output reg coreWriteSecondValid,
  output reg [31:0] coreRegFirstOut,
  output reg [31:0] coreRegSecondOut,
  output reg undefinedInstr,
  output reg fpExceptionRaised,
  // Exception capture from the arithmetic pipeline
  input wire excEvent,
  input wire [7:0] excType,
  input wire [2:0] excIterationsLeft,
  input wire [31:0] excInstr,
  input wire excFollowValid,
  input wire [31:0] excFollowInstr,
  // Coprocessor state
  output wire coprocEnabled,
  output wire [31:0] statusControl
);
  // Register file and system register state.
  wire [31:0] fpRegs [0:31];
  reg [31:0] fpStatusControl;
  reg [31:0] fpExceptionControl;
  reg [31:0] fpExceptionalInstruction;
  reg [31:0] fpFollowingInstruction;

  // Index decode.
  wire [4:0] firstSingle;
  wire [4:0] secondSingle;
  wire [4:0] doubleLow;
  wire [4:0] doubleHigh;
  reg [31:0] sysRead;
  reg selValid;
  reg accessOk;
  wire doIt;
  wire isSys;

  wire [31:0] doubleLowHot;
  wire [31:0] doubleHighHot;
  wire [31:0] firstSingleHot;
  wire [31:0] secondSingleHot;
  wire sysWrite;
  wire sysAllowed;
  reg writable;
  reg [4:0] readFirstIndex;
  reg [4:0] readSecondIndex;
  reg [31:0] writeFirstHot;
  reg [31:0] writeSecondHot;

  // Next values of the registered outputs and system registers.
  reg next_coreWriteValid;
  reg next_coreWriteSecondValid;
  reg [31:0] next_coreRegFirstOut;
  reg [31:0] next_coreRegSecondOut;
  reg next_undefinedInstr;
  reg [31:0] next_statusControl;
  reg [31:0] next_exceptionControl;
  reg [31:0] next_exceptionalInstruction;
  reg [31:0] next_followingInstruction;

  fp_single_index singleIdx (
    .singleIndexHigh(singleIndexHigh),
    .singleIndexLowBit(singleIndexLowBit),
    .firstSingle(firstSingle),
    .secondSingle(secondSingle)
  );

  assign doubleLow = {doubleReg[3:0], 1'b0};
  assign doubleHigh = {doubleReg[3:0], 1'b1};
  assign coprocEnabled = fpExceptionControl[`EXC_ENABLE_BIT];
  assign statusControl = fpStatusControl;
  assign doIt = issueValid && conditionPassed;
  assign isSys = (issueOp == `OP_SYSREG_READ) || (issueOp == `OP_SYSREG_WRITE);
  assign sysAllowed = selValid && accessOk;
  assign sysWrite = doIt && isSys && (issueOp == `OP_SYSREG_WRITE) && sysAllowed && writable;
  assign doubleLowHot = 32'h00000001 << doubleLow;
  assign doubleHighHot = 32'h00000001 << doubleHigh;
  assign firstSingleHot = 32'h00000001 << firstSingle;
  assign secondSingleHot = 32'h00000001 << secondSingle;

  // System-register read mux and select check.
  always @* begin
    sysRead = 32'h00000000;
    selValid = 1'b1;
    case (sysregSelect)
      `SEL_SYSTEM_ID: begin
        sysRead = SYSTEM_ID;
      end
      `SEL_STATUS_CONTROL: begin
        sysRead = fpStatusControl;
      end
      `SEL_EXCEPTION: begin
        sysRead = fpExceptionControl;
      end
      `SEL_EXC_INSTR: begin
        sysRead = fpExceptionalInstruction;
      end
      `SEL_FOLLOW_INSTR: begin
        sysRead = fpFollowingInstruction;
      end
      `SEL_FEATURES_LOW: begin
        sysRead = `RST_FEATURES_LOW;
      end
      `SEL_FEATURES_HIGH: begin
        sysRead = `RST_FEATURES_HIGH;
      end
      default: begin
        selValid = 1'b0;
      end
    endcase
  end

  // Privilege and enable check for the selected register.
  always @* begin
    accessOk = 1'b0;
    case (sysregSelect)
      `SEL_STATUS_CONTROL: begin
        accessOk = coprocEnabled;
      end
      `SEL_EXCEPTION, `SEL_EXC_INSTR, `SEL_FOLLOW_INSTR: begin
        accessOk = privilegedMode;
      end
      `SEL_SYSTEM_ID, `SEL_FEATURES_LOW, `SEL_FEATURES_HIGH: begin
        accessOk = coprocEnabled || privilegedMode;
      end
      default: begin
        accessOk = 1'b0;
      end
    endcase
  end

  // Only the status, exception and instruction registers take writes.
  always @* begin
    writable = 1'b0;
    case (sysregSelect)
      `SEL_STATUS_CONTROL, `SEL_EXCEPTION: begin
        writable = 1'b1;
      end
      `SEL_EXC_INSTR, `SEL_FOLLOW_INSTR: begin
        writable = 1'b1;
      end
      `SEL_SYSTEM_ID, `SEL_FEATURES_LOW, `SEL_FEATURES_HIGH: begin
        writable = 1'b0;
      end
      default: begin
        writable = 1'b0;
      end
    endcase
  end

  // Source entries of a pair read towards the core.
  always @* begin
    readFirstIndex = firstSingle;
    readSecondIndex = secondSingle;
    case (issueOp)
      `OP_DOUBLE_TO_CORE: begin
        readFirstIndex = doubleLow;
        readSecondIndex = doubleHigh;
      end
      `OP_SINGLES_TO_CORE: begin
        readFirstIndex = firstSingle;
        readSecondIndex = secondSingle;
      end
      default: begin
        readFirstIndex = firstSingle;
        readSecondIndex = secondSingle;
      end
    endcase
  end

  // Destination entries of a pair write from the core.
  always @* begin
    writeFirstHot = 32'h00000000;
    writeSecondHot = 32'h00000000;
    if (doIt) begin
      case (issueOp)
        `OP_CORE_TO_DOUBLE: begin
          writeFirstHot = doubleLowHot;
          writeSecondHot = doubleHighHot;
        end
        `OP_CORE_TO_SINGLES: begin
          writeFirstHot = firstSingleHot;
          writeSecondHot = secondSingleHot;
        end
        default: begin
          writeFirstHot = 32'h00000000;
          writeSecondHot = 32'h00000000;
        end
      endcase
    end
  end

  // Results towards the core and the undefined-instruction pulse.
  always @* begin
    next_coreWriteValid = 1'b0;
    next_coreWriteSecondValid = 1'b0;
    next_coreRegFirstOut = coreRegFirstOut;
    next_coreRegSecondOut = coreRegSecondOut;
    next_undefinedInstr = 1'b0;
    if (doIt) begin
      case (issueOp)
        `OP_DOUBLE_TO_CORE, `OP_SINGLES_TO_CORE: begin
          next_coreRegFirstOut = fpRegs[readFirstIndex];
          next_coreRegSecondOut = fpRegs[readSecondIndex];
          next_coreWriteValid = 1'b1;
          next_coreWriteSecondValid = 1'b1;
        end
        `OP_SYSREG_READ: begin
          if (sysAllowed) begin
            next_coreRegFirstOut = sysRead;
            next_coreWriteValid = 1'b1;
          end else begin
            next_undefinedInstr = 1'b1;
          end
        end
        `OP_SYSREG_WRITE: begin
          if (!sysAllowed) begin
            next_undefinedInstr = 1'b1;
          end
        end
        default: begin
          next_undefinedInstr = 1'b0;
        end
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      coreWriteValid <= 1'b0;
      coreWriteSecondValid <= 1'b0;
      coreRegFirstOut <= 32'h00000000;
      coreRegSecondOut <= 32'h00000000;
      undefinedInstr <= 1'b0;
      fpExceptionRaised <= 1'b0;
    end else begin
      coreWriteValid <= next_coreWriteValid;
      coreWriteSecondValid <= next_coreWriteSecondValid;
      coreRegFirstOut <= next_coreRegFirstOut;
      coreRegSecondOut <= next_coreRegSecondOut;
      undefinedInstr <= next_undefinedInstr;
      fpExceptionRaised <= 1'b0;
    end
  end

  // One row of flops per register entry.
  genvar entry;
  generate
    for (entry = 0; entry < 32; entry = entry + 1) begin : gEntry
      reg [31:0] entryValue;
      wire takeFirst;
      wire takeSecond;
      assign takeFirst = writeFirstHot[entry];
      assign takeSecond = writeSecondHot[entry];
      assign fpRegs[entry] = entryValue;
      always @(posedge core_clk) begin
        if (takeSecond) begin
          entryValue <= coreRegSecondIn;
        end else if (takeFirst) begin
          entryValue <= coreRegFirstIn;
        end
      end
    end
  endgenerate

  // System-register update; a captured exception wins over a software write in the fields and registers it loads.
  always @* begin
    next_statusControl = fpStatusControl;
    next_exceptionControl = fpExceptionControl;
    next_exceptionalInstruction = fpExceptionalInstruction;
    next_followingInstruction = fpFollowingInstruction;
    if (sysWrite) begin
      case (sysregSelect)
        `SEL_STATUS_CONTROL: begin
          next_statusControl = issueWord;
        end
        `SEL_EXCEPTION: begin
          next_exceptionControl = issueWord;
        end
        `SEL_EXC_INSTR: begin
          next_exceptionalInstruction = issueWord;
        end
        `SEL_FOLLOW_INSTR: begin
          next_followingInstruction = issueWord;
        end
        default: begin
          next_statusControl = fpStatusControl;
        end
      endcase
    end
    if (excEvent) begin
      next_exceptionControl[`EXC_PENDING_BIT] = 1'b1;
      next_exceptionControl[`EXC_TYPE_MSB:`EXC_TYPE_LSB] = excType;
      next_exceptionControl[`EXC_ITER_MSB:`EXC_ITER_LSB] = excIterationsLeft;
      next_exceptionControl[`EXC_FOLLOW_VALID_BIT] = excFollowValid;
      next_exceptionalInstruction = excInstr;
      if (excFollowValid) begin
        next_followingInstruction = excFollowInstr;
      end
    end
  end

  // System-register flops.
  always @(posedge core_clk) begin
    if (rst) begin
      fpStatusControl <= `RST_STATUS_CONTROL;
      fpExceptionControl <= `RST_EXCEPTION;
      fpExceptionalInstruction <= `RST_EXC_INSTR;
      fpFollowingInstruction <= `RST_FOLLOW_INSTR;
    end else begin
      fpStatusControl <= next_statusControl;
      fpExceptionControl <= next_exceptionControl;
      fpExceptionalInstruction <= next_exceptionalInstruction;
      fpFollowingInstruction <= next_followingInstruction;
    end
  end
endmodule // fp_coprocessor_transfer_access
`default_nettype wire

// ### rtl/fp_single_index.v
// Forms the single register number of a pair and its successor.
`timescale 1ns/100ps
`default_nettype none
module fp_single_index (
  // Instruction fields
  input wire [3:0] singleIndexHigh,
  input wire singleIndexLowBit,
  // Register numbers
  output wire [4:0] firstSingle,
  output wire [4:0] secondSingle
);
  assign firstSingle = {singleIndexHigh, singleIndexLowBit};
  assign secondSingle = firstSingle + 5'h01;
endmodule // fp_single_index
`default_nettype wire

// ### rtl/fp_xfer_regs.vh
// Constants for the floating-point register-transfer and system-register access block.
`ifndef FP_XFER_REGS_VH
`define FP_XFER_REGS_VH
`define SEL_SYSTEM_ID 4'h0
`define SEL_STATUS_CONTROL 4'h1
`define SEL_FEATURES_HIGH 4'h6
`define SEL_FEATURES_LOW 4'h7
`define SEL_EXCEPTION 4'h8
`define SEL_EXC_INSTR 4'h9
`define SEL_FOLLOW_INSTR 4'hA
`define RST_STATUS_CONTROL 32'h00000000
`define RST_EXCEPTION 32'h00000000
`define RST_EXC_INSTR 32'hEE000A00
`define RST_FOLLOW_INSTR 32'h00000000
`define RST_FEATURES_LOW 32'h11111111
`define RST_FEATURES_HIGH 32'h00000000
`define EXC_ENABLE_BIT 30
`define EXC_PENDING_BIT 31
`define EXC_FOLLOW_VALID_BIT 28
`define EXC_ITER_LSB 8
`define EXC_ITER_MSB 10
`define EXC_TYPE_LSB 0
`define EXC_TYPE_MSB 7
`define OP_NONE 3'h0
`define OP_CORE_TO_DOUBLE 3'h1
`define OP_DOUBLE_TO_CORE 3'h2
`define OP_CORE_TO_SINGLES 3'h3
`define OP_SINGLES_TO_CORE 3'h4
`define OP_SYSREG_READ 3'h5
`define OP_SYSREG_WRITE 3'h6
`endif

// ### verif/fp_coprocessor_transfer_access_tb_top.sv
// Testbench for the pair-transfer and system-register block.
`timescale 1ns/100ps
`default_nettype none
module fp_coprocessor_transfer_access_tb_top;
  localparam [31:0] ID = 32'h5A5A0001;
  logic core_clk = 0, rst = 1, issueValid = 0, conditionPassed = 1, privilegedMode = 1;
  logic singleIndexLowBit = 0, excEvent = 0, excFollowValid = 0, presetValid = 0;
  logic [2:0] issueOp = 0, excIterationsLeft = 0;
  logic [3:0] singleIndexHigh = 0, sysregSelect = 0;
  logic [4:0] doubleReg = 0;
  logic [7:0] excType = 0;
  logic [31:0] issueWord = 0, excInstr = 0, excFollowInstr = 0, presetFirst = 0, presetSecond = 0;
  wire coreWriteValid, coreWriteSecondValid, undefinedInstr, fpExceptionRaised, coprocEnabled;
  wire [31:0] coreRegFirstIn, coreRegSecondIn, coreRegFirstOut, coreRegSecondOut, statusControl;
  int n_errors = 0;
  int n_tests = 0;
  fp_coprocessor_transfer_access #(.SYSTEM_ID(ID)) i_fp_coprocessor_transfer_access (.*);
  fp_core_model i_fp_core_model (.*);
  always #5 core_clk = ~core_clk;
  task automatic give_verdict;
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Issues one instruction and checks the response flags one cycle later.
  task automatic go(input logic [2:0] op, input logic [4:0] a, input logic [31:0] w, v, u);
    @(posedge core_clk) #1;
    issueOp = op;
    doubleReg = a;
    sysregSelect = a[3:0];
    {singleIndexHigh, singleIndexLowBit} = a;
    issueWord = w;
    issueValid = 1;
    @(posedge core_clk) #1 issueValid = 0;
    chk(coreWriteValid, v);
    chk(undefinedInstr, u);
  endtask
  task automatic preset(input logic [31:0] f, s);
    @(posedge core_clk) #1;
    presetFirst = f;
    presetSecond = s;
    presetValid = 1;
    @(posedge core_clk) #1 presetValid = 0;
  endtask
  task automatic t_reset;
    logic [3:0] s[5];
    logic [31:0] e[5];
    s = '{4'h0, 4'h8, 4'h9, 4'h7, 4'h6};
    e = '{ID, 32'h0, 32'hEE000A00, 32'h11111111, 32'h0};
    for (int i = 0; i < 5; i++) begin
      go(3'h5, {1'b0, s[i]}, 0, 1, 0);
      chk(coreRegFirstOut, e[i]);
    end
    go(3'h5, 5'h01, 0, 0, 1);
    go(3'h5, 5'h02, 0, 0, 1);
    privilegedMode = 0;
    go(3'h5, 5'h00, 0, 0, 1);
    go(3'h6, 5'h01, 0, 0, 1);
    privilegedMode = 1;
  endtask
  task automatic t_sys;
    go(3'h6, 5'h08, 32'h40000000, 0, 0);
    chk(coprocEnabled, 1);
    privilegedMode = 0;
    go(3'h6, 5'h01, 32'h03C00000, 0, 0);
    go(3'h5, 5'h01, 0, 1, 0);
    chk(coreRegFirstOut, 32'h03C00000);
    chk(statusControl, 32'h03C00000);
    go(3'h5, 5'h07, 0, 1, 0);
    go(3'h5, 5'h09, 0, 0, 1);
    privilegedMode = 1;
    go(3'h6, 5'h00, 32'h12345678, 0, 0);
    go(3'h5, 5'h00, 0, 1, 0);
    chk(coreRegFirstOut, ID);
  endtask
  // Pair m=31 is never issued here.
  task automatic t_pair;
    preset(32'h89ABCDEF, 32'h01234567);
    go(3'h1, 5'h01, 0, 0, 0);
    go(3'h2, 5'h01, 0, 1, 0);
    chk(coreWriteSecondValid, 1);
    chk(coreRegSecondOut, 32'h01234567);
    go(3'h4, 5'h02, 0, 1, 0);
    chk(coreRegFirstOut, 32'h89ABCDEF);
    preset(32'hFFFF0000, 32'h7FC00001);
    go(3'h3, 5'h05, 0, 0, 0);
    go(3'h4, 5'h05, 0, 1, 0);
    chk({coreRegFirstOut[31:16], coreRegSecondOut[15:0]}, 32'hFFFF0001);
    conditionPassed = 0;
    go(3'h1, 5'h01, 0, 0, 0);
    conditionPassed = 1;
    go(3'h2, 5'h01, 0, 1, 0);
    chk(coreRegFirstOut, 32'h89ABCDEF);
  endtask
  task automatic t_exc;
    @(posedge core_clk) #1;
    {excType, excIterationsLeft, excFollowValid} = {8'h5A, 3'h5, 1'b1};
    {excInstr, excFollowInstr, excEvent} = {32'hC0DE0001, 32'hC0DE0002, 1'b1};
    @(posedge core_clk) #1 excEvent = 0;
    go(3'h5, 5'h08, 0, 1, 0);
    chk(coreRegFirstOut, 32'hD000055A);
    go(3'h5, 5'h0A, 0, 1, 0);
    chk(coreRegFirstOut, 32'hC0DE0002);
    go(3'h5, 5'h09, 0, 1, 0);
    chk(coreRegFirstOut, 32'hC0DE0001);
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    #1 rst = 0;
    t_reset;
    t_sys;
    t_pair;
    t_exc;
    give_verdict;
  end
endmodule // fp_coprocessor_transfer_access_tb_top
`default_nettype wire

// ### verif/fp_core_model.sv
// Model of the core integer registers facing the transfer block.
`timescale 1ns/100ps
`default_nettype none
module fp_core_model (
  // Clock and preset
  input wire core_clk, presetValid,
  input wire [31:0] presetFirst, presetSecond,
  // Results from the block
  input wire coreWriteValid, coreWriteSecondValid,
  input wire [31:0] coreRegFirstOut, coreRegSecondOut,
  // Values to the block
  output var logic [31:0] coreRegFirstIn, coreRegSecondIn
);
  // Only two registers exist, so the program counter is never a destination.
  always @(posedge core_clk) begin
    if (presetValid) begin
      coreRegFirstIn <= presetFirst;
      coreRegSecondIn <= presetSecond;
    end else begin
      if (coreWriteValid) coreRegFirstIn <= coreRegFirstOut;
      if (coreWriteSecondValid) coreRegSecondIn <= coreRegSecondOut;
    end
  end
endmodule // fp_core_model
`default_nettype wire

// ### verif/fp_xfer_chk.sv
// Assertion checker for the pair-transfer and system-register block.
`timescale 1ns/100ps
`default_nettype none
module fp_xfer_chk #(parameter [31:0] SYSTEM_ID = 32'h00C0FFEE) (
  // Issue
  input wire core_clk, rst, issueValid, conditionPassed, privilegedMode,
  input wire [2:0] issueOp,
  input wire [3:0] sysregSelect,
  input wire [31:0] issueWord,
  // Results
  input wire coreWriteValid, coreWriteSecondValid, undefinedInstr, fpExceptionRaised,
  input wire coprocEnabled,
  input wire [31:0] coreRegFirstOut, statusControl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire t = issueValid && conditionPassed;
  wire rd = t && issueOp == 3'h5;
  wire wr = t && issueOp == 3'h6;
  property p_pair; t && issueOp == 3'h2 |=> coreWriteValid && coreWriteSecondValid; endproperty
  a_pair: assert property (p_pair) else $error("pair");
  property p_skip; issueValid && !conditionPassed |=> !coreWriteValid && !undefinedInstr; endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_fpe; !fpExceptionRaised; endproperty
  a_fpe: assert property (p_fpe) else $error("fpe");
  property p_off; (rd || wr) && sysregSelect == 4'h1 && !coprocEnabled |=> undefinedInstr; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_priv;
    (rd || wr) && sysregSelect[3] && !privilegedMode |=> undefinedInstr && !coreWriteValid;
  endproperty
  a_priv: assert property (p_priv) else $error("priv");
  property p_id; rd && sysregSelect == 4'h0 && coprocEnabled |=> coreRegFirstOut == SYSTEM_ID; endproperty
  a_id: assert property (p_id) else $error("id");
  property p_stw;
    wr && sysregSelect == 4'h1 && coprocEnabled |=> statusControl == $past(issueWord);
  endproperty
  a_stw: assert property (p_stw) else $error("stw");
  property p_hold; !(wr && sysregSelect == 4'h1) |=> $stable(statusControl); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_in; t && (issueOp == 3'h1 || issueOp == 3'h3) |=> !coreWriteValid; endproperty
  a_in: assert property (p_in) else $error("in");
  c_priv: cover property (rd && !privilegedMode);
  c_sgl: cover property (t && issueOp == 3'h4);
  c_und: cover property (undefinedInstr);
endmodule // fp_xfer_chk
bind fp_coprocessor_transfer_access fp_xfer_chk #(.SYSTEM_ID(SYSTEM_ID)) i_fp_xfer_chk (.*);
`default_nettype wire
